// >>> hdl/fmt_consts.svh
// Offsets, field positions and reset values of the pixel output formatter
`ifndef FMT_CONSTS_SVH
`define FMT_CONSTS_SVH
`define FMT_ADDR_W       12
`define FMT_CTRL_OFS     12'h000
`define FMT_STATUS_OFS   12'h004
`define FMT_LINES_OFS    12'h008
`define FMT_MODE_LSB     0
`define FMT_MODE_W       3
`define FMT_CLK80_BIT    8
`define FMT_ENABLE_BIT   16
`define FMT_MODE_RST     3'h0
`define FMT_CLK80_RST    1'b0
`define FMT_ENABLE_RST   1'b0
`define FMT_ST_INLINE    0
`define FMT_ST_MODE_LSB  4
`define FMT_ST_CLK80     8
`define FMT_SAMPLE_W     12
`define FMT_MAX_TAPS     8
`define FMT_SER_W        24
`endif

// >>> hdl/fmt_pkg.sv
// Types shared by the pixel output formatter
package fmt_pkg;
  typedef enum logic [2:0] {
    MODE_2T8  = 3'b000,
    MODE_2T10 = 3'b001,
    MODE_2T12 = 3'b010,
    MODE_4T8  = 3'b011,
    MODE_4T10 = 3'b100,
    MODE_4T12 = 3'b101,
    MODE_8T8  = 3'b110
  } mode_t;
  typedef enum logic [1:0] {
    DEPTH_8  = 2'b00,
    DEPTH_10 = 2'b01,
    DEPTH_12 = 2'b10
  } depth_t;
  typedef enum logic [0:0] {
    LINE_IDLE = 1'b0,
    LINE_BUSY = 1'b1
  } line_state_t;
endpackage : fmt_pkg

// >>> hdl/pixel_output_formatter.sv
// Multi-tap pixel output formatter with APB control registers
//
// Function
// - Two, four or eight pixels leave per pixel-clock cycle depending on tap count.
// - Pixel clock speed selectable between 40 MHz and 80 MHz.
// - Two and four taps at 8, 10, 12 bits; eight taps at 8 only.
// - Two-tap twelve-bit: two 12-bit pixels plus line-valid and data-valid per cycle.
// - Two-tap formats use only the first serializer port, others stay idle.
// - Data and qualifiers launch on each pixel clock rising edge.
// - A word is valid only when line-valid and data-valid are both high.
// - Ten-bit formats drop the two low bits of each sample.
// - Eight-bit formats drop the four low bits of each sample.
// - Software mode field selects tap count and pixel depth.
// - Pixel depth never changes line-valid delay or frame timing.
// - More taps means proportionally fewer cycles per line.
// - Line-valid and data-valid low on every cycle without a valid pixel.
// - Line-valid and data-valid rise together with the first pixel pair.
// - First stream odd pixels, second stream even pixels, advancing by two.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "fmt_consts.svh"

module pixel_output_formatter
  import fmt_pkg::*;
(
  // Clock and reset
  input  wire logic                         SYS_CLK,
  input  wire logic                         RST_N,
  // APB slave
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [`FMT_ADDR_W-1:0]       PADDR,
  input  wire logic [31:0]                  PWDATA,
  output logic      [31:0]                  PRDATA,
  output logic                              PREADY,
  output logic                              PSLVERR,
  // Pixel source, sample k of a beat in bits [12k+11:12k]
  input  wire logic                         PIX_VALID,
  input  wire logic                         PIX_LAST,
  input  wire logic [`FMT_MAX_TAPS*12-1:0]  PIX_DATA,
  output logic                              PIX_READY,
  // Link pixel clock from the link transmitter
  input  wire logic                         PCLK_IN,
  // Link outputs
  output logic      [`FMT_SER_W-1:0]        SER_X_DATA,
  output logic      [`FMT_SER_W-1:0]        SER_Y_DATA,
  output logic      [`FMT_SER_W-1:0]        SER_Z_DATA,
  output logic                              LINE_VALID,
  output logic                              DATA_VALID,
  output logic                              SER_X_CLK,
  output logic                              SER_YZ_CLK,
  output logic                              CLK_SEL_80
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic depth_t depth_of(input mode_t m);
    case (m)
      MODE_2T10, MODE_4T10: depth_of = DEPTH_10;
      MODE_2T12, MODE_4T12: depth_of = DEPTH_12;
      default:              depth_of = DEPTH_8;
    endcase
  endfunction

  function automatic logic [3:0] taps_of(input mode_t m);
    case (m)
      MODE_4T8, MODE_4T10, MODE_4T12: taps_of = 4'h4;
      MODE_8T8:                       taps_of = 4'h8;
      default:                        taps_of = 4'h2;
    endcase
  endfunction

  function automatic logic mode_ok(input logic [2:0] v);
    mode_ok = (v <= 3'h6);
  endfunction

  // Packs two samples into ports A, B, C of one serializer
  function automatic logic [23:0] pack2(input depth_t d, input logic [11:0] s0,
                                        input logic [11:0] s1);
    logic [11:0] p0;
    logic [11:0] p1;
    p0 = 12'h000;
    p1 = 12'h000;
    case (d)
      DEPTH_12: begin
        pack2 = {s1[7:0], s1[11:8], s0[11:8], s0[7:0]};
      end
      DEPTH_10: begin
        p0 = {2'b00, s0[11:2]};
        p1 = {2'b00, s1[11:2]};
        pack2 = {p1[7:0], 2'b00, p1[9:8], 2'b00, p0[9:8], p0[7:0]};
      end
      default: begin
        p0 = {4'h0, s0[11:4]};
        p1 = {4'h0, s1[11:4]};
        pack2 = {8'h00, p1[7:0], p0[7:0]};
      end
    endcase
  endfunction

  function automatic logic [7:0] top8(input logic [11:0] s);
    top8 = s[11:4];
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [2:0]  mode_r, mode_nxt;
  logic        clk80_r, clk80_nxt;
  logic        enable_r, enable_nxt;
  logic [15:0] lines_r, lines_nxt;
  logic        access;
  logic        hit_ctrl, hit_status, hit_lines;

  assign access     = PSEL & PENABLE;
  assign hit_ctrl   = (PADDR == `FMT_CTRL_OFS);
  assign hit_status = (PADDR == `FMT_STATUS_OFS);
  assign hit_lines  = (PADDR == `FMT_LINES_OFS);
  assign PREADY     = 1'b1;
  assign PSLVERR    = access & ~(hit_ctrl | hit_status | hit_lines);

  // ****************************************
  // Link clock edge finder
  // ****************************************
  logic pclk_s1_r, pclk_s2_r, pclk_s3_r;
  logic pclk_rise;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pclk_s1_r <= 1'b0;
      pclk_s2_r <= 1'b0;
      pclk_s3_r <= 1'b0;
    end else begin
      pclk_s1_r <= PCLK_IN;
      pclk_s2_r <= pclk_s1_r;
      pclk_s3_r <= pclk_s2_r;
    end
  end

  assign pclk_rise = pclk_s2_r & ~pclk_s3_r;

  // ****************************************
  // Line sequencer
  // ****************************************
  line_state_t state_r, state_nxt;
  mode_t       act_mode_r, act_mode_nxt;
  logic [23:0] ser_x_r, ser_x_nxt;
  logic [23:0] ser_y_r, ser_y_nxt;
  logic [23:0] ser_z_r, ser_z_nxt;
  logic        lval_r, lval_nxt;
  logic        dval_r, dval_nxt;
  logic        clk_x_r, clk_yz_r;
  logic        take;
  logic        tail_r, tail_nxt;
  depth_t      dep;
  logic [11:0] smp [0:7];

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      smp[i] = PIX_DATA[12*i +: 12];
    end
  end

  assign dep       = depth_of(act_mode_r);
  // The rise after a line's last beat is refused so both qualifiers drop between lines
  assign PIX_READY = pclk_rise & enable_r & ~tail_r;
  assign take      = PIX_READY & PIX_VALID;

  always_comb begin
    state_nxt    = state_r;
    act_mode_nxt = act_mode_r;
    ser_x_nxt    = ser_x_r;
    ser_y_nxt    = ser_y_r;
    ser_z_nxt    = ser_z_r;
    lval_nxt     = lval_r;
    dval_nxt     = dval_r;
    lines_nxt    = lines_r;
    tail_nxt     = tail_r;
    // Waits for the qualifiers to drop so the last word keeps its format
    if (state_r == LINE_IDLE && !take && !lval_r) begin
      act_mode_nxt = mode_t'(mode_r);
    end
    if (pclk_rise) begin
      tail_nxt = take & PIX_LAST;
      lval_nxt = take;
      dval_nxt = take;
      if (take) begin
        // Beat uses the mode latched while idle
        ser_x_nxt = pack2(dep, smp[0], smp[1]);
        ser_y_nxt = 24'h000000;
        ser_z_nxt = 24'h000000;
        case (taps_of(act_mode_r))
          4'h4: ser_y_nxt = pack2(dep, smp[2], smp[3]);
          4'h8: begin
            ser_x_nxt = {top8(smp[2]), top8(smp[1]), top8(smp[0])};
            ser_y_nxt = {top8(smp[5]), top8(smp[4]), top8(smp[3])};
            ser_z_nxt = {8'h00, top8(smp[7]), top8(smp[6])};
          end
          default: ser_y_nxt = 24'h000000;
        endcase
        state_nxt = PIX_LAST ? LINE_IDLE : LINE_BUSY;
        if (PIX_LAST) begin
          lines_nxt = lines_r + 16'h0001;
        end
      end else begin
        ser_x_nxt = 24'h000000;
        ser_y_nxt = 24'h000000;
        ser_z_nxt = 24'h000000;
      end
    end
    if (!enable_r) begin
      state_nxt = LINE_IDLE;
    end
    if (access && PWRITE && hit_lines) begin
      lines_nxt = 16'h0000;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r    <= LINE_IDLE;
      act_mode_r <= MODE_2T8;
      ser_x_r    <= 24'h000000;
      ser_y_r    <= 24'h000000;
      ser_z_r    <= 24'h000000;
      lval_r     <= 1'b0;
      dval_r     <= 1'b0;
      lines_r    <= 16'h0000;
      clk_x_r    <= 1'b0;
      clk_yz_r   <= 1'b0;
      tail_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      act_mode_r <= act_mode_nxt;
      ser_x_r    <= ser_x_nxt;
      ser_y_r    <= ser_y_nxt;
      ser_z_r    <= ser_z_nxt;
      lval_r     <= lval_nxt;
      dval_r     <= dval_nxt;
      lines_r    <= lines_nxt;
      tail_r     <= tail_nxt;
      clk_x_r    <= pclk_s3_r;
      clk_yz_r   <= pclk_s3_r & (taps_of(act_mode_r) != 4'h2);
    end
  end

  assign SER_X_DATA = ser_x_r;
  assign SER_Y_DATA = ser_y_r;
  assign SER_Z_DATA = ser_z_r;
  assign LINE_VALID = lval_r;
  assign DATA_VALID = dval_r;
  assign SER_X_CLK  = clk_x_r;
  assign SER_YZ_CLK = clk_yz_r;
  assign CLK_SEL_80 = clk80_r;

  // ****************************************
  // Control register writes and reads
  // ****************************************
  always_comb begin
    mode_nxt   = mode_r;
    clk80_nxt  = clk80_r;
    enable_nxt = enable_r;
    if (access && PWRITE && hit_ctrl) begin
      if (mode_ok(PWDATA[`FMT_MODE_LSB +: `FMT_MODE_W])) begin
        mode_nxt = PWDATA[`FMT_MODE_LSB +: `FMT_MODE_W];
      end
      clk80_nxt  = PWDATA[`FMT_CLK80_BIT];
      enable_nxt = PWDATA[`FMT_ENABLE_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_r   <= `FMT_MODE_RST;
      clk80_r  <= `FMT_CLK80_RST;
      enable_r <= `FMT_ENABLE_RST;
    end else begin
      mode_r   <= mode_nxt;
      clk80_r  <= clk80_nxt;
      enable_r <= enable_nxt;
    end
  end

  always_comb begin
    PRDATA = 32'h00000000;
    if (access && !PWRITE) begin
      if (hit_ctrl) begin
        PRDATA[`FMT_MODE_LSB +: `FMT_MODE_W] = mode_r;
        PRDATA[`FMT_CLK80_BIT]              = clk80_r;
        PRDATA[`FMT_ENABLE_BIT]             = enable_r;
      end else if (hit_status) begin
        PRDATA[`FMT_ST_INLINE]                 = (state_r == LINE_BUSY);
        PRDATA[`FMT_ST_MODE_LSB +: `FMT_MODE_W] = act_mode_r;
        PRDATA[`FMT_ST_CLK80]                  = clk80_r;
      end else if (hit_lines) begin
        PRDATA[15:0] = lines_r;
      end
    end
  end

endmodule // pixel_output_formatter
`default_nettype wire

// >>> test/fmt_chk_sva.sv
// Port assertions for the pixel output formatter
`timescale 1ns/100ps
`default_nettype none
module fmt_chk (
  // Clock, reset and register bus
  input wire logic        SYS_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  // Pixel source and link
  input wire logic        PIX_VALID, PIX_READY, PCLK_IN, LINE_VALID, DATA_VALID,
  input wire logic        SER_X_CLK, SER_YZ_CLK, PIX_LAST,
  input wire logic [23:0] SER_X_DATA
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire acc = PSEL && PENABLE;
  // Set by a line's last beat, cleared once the qualifiers have dropped
  logic tail_r;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) tail_r <= 1'b0;
    else if (PIX_READY && PIX_VALID) tail_r <= PIX_LAST;
    else if (!LINE_VALID) tail_r <= 1'b0;
  end
  sequence beat_s;
    PIX_READY && PIX_VALID;
  endsequence
  AST_ZERO_WAIT: assert property (acc |-> PREADY)
    else $error("bus wait state seen");
  AST_UNMAPPED: assert property (acc && PADDR > 12'h008 |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  AST_RDATA_IDLE: assert property (!acc || PWRITE |-> PRDATA == 32'h0)
    else $error("read data outside read access");
  AST_QUAL_PAIR: assert property (LINE_VALID == DATA_VALID)
    else $error("qualifiers differ");
  AST_IDLE_DATA: assert property (!LINE_VALID |-> SER_X_DATA == 24'h0)
    else $error("data without qualifiers");
  AST_READY_PULSE: assert property (PIX_READY |=> !PIX_READY [*3])
    else $error("ready longer than one cycle");
  AST_READY_SYNC: assert property (PIX_READY |-> $past(PCLK_IN, 2) && !$past(PCLK_IN, 3))
    else $error("ready not tied to pixel clock rise");
  AST_TAKE: assert property (beat_s |=> LINE_VALID && DATA_VALID)
    else $error("beat taken without qualifiers");
  AST_LINE_GAP: assert property (tail_r && LINE_VALID |-> !PIX_READY)
    else $error("next line started before qualifiers dropped");
  AST_NO_BEAT: assert property (PIX_READY && !PIX_VALID |=> !LINE_VALID)
    else $error("qualifiers high without a beat");
  AST_CLK_PAIR: assert property (SER_YZ_CLK |-> SER_X_CLK)
    else $error("second clock differs from first");
endmodule // fmt_chk
bind pixel_output_formatter fmt_chk chk_u (.SYS_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE,
  .PREADY, .PSLVERR, .PADDR, .PRDATA, .PIX_VALID, .PIX_READY, .PCLK_IN, .LINE_VALID,
  .DATA_VALID, .SER_X_CLK, .SER_YZ_CLK, .SER_X_DATA, .PIX_LAST);
`default_nettype wire

// >>> test/grabber_model.sv
// Frame grabber model that keeps every qualified link word
`timescale 1ns/100ps
`default_nettype none
module grabber_model (
  // Link from the formatter
  input wire logic        link_clk, line_valid, data_valid,
  input wire logic [71:0] link_word
);
  logic [71:0] words[$];
  // Sampled on the same rising edge that the formatter launches against
  always @(posedge link_clk) begin
    if (line_valid && data_valid) words.push_back(link_word);
  end
endmodule // grabber_model
`default_nettype wire

// >>> test/multi_tap_pixel_output_formatter_tb.sv
// Self-checking bench of the pixel output formatter
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module multi_tap_pixel_output_formatter_tb
  import fmt_pkg::*;
;
  logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pclk = 0;
  logic        pix_valid = 0, pix_last = 0, pready, pslverr, pix_ready, lv, dv, er, c;
  logic        x_clk, yz_clk, clk80, yz;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [95:0] pix_data = 0;
  logic [23:0] sx, sy, sz;
  logic [95:0] beats[$];
  logic [71:0] exp_q[$], g, e;
  integer      seed = 74, fails = 0, n_tests = 0, lines = 0;
  always #12.5 sys_clk = ~sys_clk;
  initial begin
    #3;
    forever #100 pclk = ~pclk;
  end
  pixel_output_formatter dut_u (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PIX_VALID(pix_valid), .PIX_LAST(pix_last),
    .PIX_DATA(pix_data), .PIX_READY(pix_ready), .PCLK_IN(pclk), .SER_X_DATA(sx),
    .SER_Y_DATA(sy), .SER_Z_DATA(sz), .LINE_VALID(lv), .DATA_VALID(dv), .SER_X_CLK(x_clk),
    .SER_YZ_CLK(yz_clk), .CLK_SEL_80(clk80));
  grabber_model g_u (.link_clk(x_clk), .line_valid(lv), .data_valid(dv),
    .link_word({sz, sy, sx}));
  // Beat source: held until taken, released data shows an inverted pattern
  always @(posedge sys_clk) begin
    if (pix_ready && pix_valid) void'(beats.pop_front());
    pix_valid <= beats.size() > 0;
    pix_last <= beats.size() == 1;
    pix_data <= beats.size() > 0 ? beats[0] : ~pix_data;
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [23:0] pk(input int d, input logic [11:0] a, b);
    case (d)
      0: pk = {8'h00, b[11:4], a[11:4]};
      1: pk = {b[9:2], 2'b00, b[11:10], 2'b00, a[11:10], a[9:2]};
      default: pk = {b[7:0], b[11:8], a[11:8], a[7:0]};
    endcase
  endfunction
  function automatic logic [71:0] ex(input int m, input logic [95:0] s);
    logic [11:0] t[8];
    for (int k = 0; k < 8; k++) t[k] = s[12*k +: 12];
    if (m == 6) return {8'h00, t[7][11:4], t[6][11:4], t[5][11:4], t[4][11:4],
      t[3][11:4], t[2][11:4], t[1][11:4], t[0][11:4]};
    return {24'h0, m > 2 ? pk(m % 3, t[2], t[3]) : 24'h0, pk(m % 3, t[0], t[1])};
  endfunction
  task automatic send_line(input int m, input int nb, input int nxt);
    logic [95:0] b;
    @(negedge sys_clk);
    for (int i = 0; i < nb; i++) begin
      b = {$random(seed), $random(seed), $random(seed)};
      beats.push_back(b);
      exp_q.push_back(ex(m, b));
    end
    c = 1'($random(seed));
    wait (lv === 1'b1);
    apb(1, 12'h000, {15'h0, 1'b1, 7'h0, c, 5'h0, 3'(nxt)});
    wait (beats.size() == 0 && lv === 1'b0);
    repeat (20) @(posedge sys_clk);
    lines++;
    `CHK(g_u.words.size(), exp_q.size())
    while (exp_q.size() > 0 && g_u.words.size() > 0) begin
      g = g_u.words.pop_front();
      e = exp_q.pop_front();
      `CHK(g, e)
    end
    exp_q.delete();
    `CHK(clk80, c)
    apb(0, 12'h004, 32'h0);
    `CHK(rd[6:4], 3'(nxt))
    yz = 1'b0;
    repeat (8) @(posedge sys_clk) yz = yz | yz_clk;
    `CHK(yz, nxt > 2)
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1;
    apb(1, 12'h000, 32'h0001_0000);
    for (int m = 0; m < 7; m++) send_line(m, 2 + m, (m + 1) % 7);
    apb(0, 12'h008, 32'h0);
    `CHK(rd[15:0], 16'(lines))
    apb(0, 12'h00c, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1, 12'h000, 32'h0001_0007);
    apb(0, 12'h000, 32'h0);
    `CHK(rd[2:0], 3'h0)
    stop_test;
  end
endmodule // multi_tap_pixel_output_formatter_tb
`default_nettype wire
